// file: dsa_addr_step.sv
// Post-modify step and modulo wrap for one pointer
`timescale 1ns/1ps
module dsa_addr_step (
	// Pointer in
	input wire logic [15:0] ptr,
	input wire logic byte_op,
	input wire logic dec,
	// Modulo window
	input wire logic mod_en,
	input wire logic [15:0] mod_start,
	input wire logic [15:0] mod_end,
	// Result
	output logic [15:0] next_ptr
);
	logic [15:0] step;
	logic [15:0] raw;
	always_comb begin
		step = byte_op ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD;
		raw = dec ? ptr - step : ptr + step;
		next_ptr = raw;
		if (mod_en) begin
			if (!dec && ptr == mod_end - step + 16'h0001) begin
				next_ptr = mod_start;
			end else if (dec && ptr == mod_start) begin
				next_ptr = mod_end - step + 16'h0001;
			end
		end
	end
endmodule : dsa_addr_step

// file: dsa_bitrev.sv
// Bit-reversed pointer advance for X writes
`timescale 1ns/1ps
module dsa_bitrev (
	// Pointer and modifier
	input wire logic [15:0] ptr,
	input wire logic [15:0] modifier,
	// Result
	output logic [15:0] next_ptr
);
	logic [15:0] rp;
	logic [15:0] rm;
	logic [15:0] rs;
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			rp[i] = ptr[15 - i];
			rm[i] = modifier[15 - i];
		end
		rs = rp + rm;
		for (int i = 0; i < 16; i++) begin
			next_ptr[i] = rs[15 - i];
		end
	end
endmodule : dsa_bitrev

// file: dsa_mem_model.sv
// Data memory model behind the access block
`timescale 1ns/1ps
module dsa_mem_model (
	// Clock
	input wire logic ref_clk,
	// Read ports
	input wire logic mem_x_rd_en,
	input wire logic [14:0] mem_x_rd_word,
	output logic [15:0] mem_x_rd_data,
	input wire logic mem_y_rd_en,
	input wire logic [14:0] mem_y_rd_word,
	output logic [15:0] mem_y_rd_data,
	// Write port
	input wire logic [14:0] mem_wr_word,
	input wire logic [15:0] mem_wr_data,
	input wire logic mem_wr_lo,
	input wire logic mem_wr_hi
);
	logic [15:0] mem [2048];
	initial for (int i = 0; i < 2048; i++) mem[i] = {~i[7:0], i[7:0]};
	// Unselected port shows inverted data, never a stale match
	assign mem_x_rd_data = mem_x_rd_en ? mem[mem_x_rd_word[10:0]] : ~mem[mem_x_rd_word[10:0]];
	assign mem_y_rd_data = mem_y_rd_en ? mem[mem_y_rd_word[10:0]] : ~mem[mem_y_rd_word[10:0]];
	always @(posedge ref_clk) begin
		if (mem_wr_lo) mem[mem_wr_word[10:0]][7:0] <= mem_wr_data[7:0];
		if (mem_wr_hi) mem[mem_wr_word[10:0]][15:8] <= mem_wr_data[15:8];
	end
endmodule : dsa_mem_model

// file: dsa_monitor.sv
// Assertion checker for the data space access block
`timescale 1ns/1ps
module dsa_monitor #(
	parameter logic [15:0] MEM_END = dsa_pkg::MEM_END
) (
	// Clock and requests
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic x_rd_req,
	input wire logic [15:0] x_rd_addr,
	input wire logic x_rd_byte,
	input wire logic x_rd_mac,
	input wire logic x_wr_req,
	input wire logic [15:0] x_wr_addr,
	input wire logic x_wr_byte,
	input wire logic y_rd_req,
	input wire logic [15:0] y_rd_addr,
	input wire logic pm_req,
	// Results
	input wire logic mem_wr_lo,
	input wire logic mem_wr_hi,
	input wire logic x_rd_valid,
	input wire logic [15:0] x_rd_data,
	input wire logic y_rd_valid,
	input wire logic pm_valid,
	input wire logic addr_error
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire logic wodd = x_wr_req && !x_wr_byte && x_wr_addr[0];
	wire logic rodd = x_rd_req && !x_rd_byte && x_rd_addr[0];
	wire logic odd = wodd || rodd || (y_rd_req && y_rd_addr[0]);
	wr_block_a: assert property (wodd |=> addr_error && !mem_wr_lo && !mem_wr_hi) else $error("odd word write stored");
	wr_lane_a: assert property (x_wr_req && x_wr_byte && x_wr_addr <= MEM_END
		|=> mem_wr_hi == $past(x_wr_addr[0]) && mem_wr_lo != $past(x_wr_addr[0])) else $error("byte lane wrong");
	wr_cause_a: assert property (mem_wr_lo || mem_wr_hi |-> $past(x_wr_req)) else $error("store without request");
	rd_odd_a: assert property (rodd |=> addr_error ##1 x_rd_valid) else $error("odd word read mishandled");
	err_cause_a: assert property (addr_error |-> $past(odd)) else $error("address error without cause");
	x_lat_a: assert property (x_rd_req |-> ##2 x_rd_valid) else $error("x read not answered");
	y_lat_a: assert property (y_rd_req |-> ##2 y_rd_valid) else $error("y read not answered");
	byte_lo_a: assert property (x_rd_req && x_rd_byte |-> ##2 x_rd_data[15:8] == 8'h00) else $error("byte upper lane set");
	bad_zero_a: assert property (x_rd_req && x_rd_addr > MEM_END |-> ##2 x_rd_data == 16'h0000) else $error("bad read not zero");
	pm_lat_a: assert property (pm_req |=> pm_valid) else $error("pointer step missing");
	cover property (wodd);
	cover property (x_rd_req && x_rd_mac);
	cover property (y_rd_req && y_rd_addr[0]);
endmodule : dsa_monitor
bind dual_bus_data_space_access dsa_monitor #(.MEM_END(MEM_END)) u_mon (.ref_clk, .srst, .x_rd_req, .x_rd_addr,
	.x_rd_byte, .x_rd_mac, .x_wr_req, .x_wr_addr, .x_wr_byte, .y_rd_req, .y_rd_addr, .pm_req, .mem_wr_lo,
	.mem_wr_hi, .x_rd_valid, .x_rd_data, .y_rd_valid, .pm_valid, .addr_error);

// file: dsa_pkg.sv
// Shared constants for the dual-bus data space access block
package dsa_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	// Fixed X/Y boundary and top of implemented memory (byte addresses)
	localparam logic [15:0] Y_BASE = 16'h0C00;
	localparam logic [15:0] Y_END = 16'h0FFF;
	localparam logic [15:0] MEM_END = 16'h0FFF;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [1:0] PTR_XA = 2'h0;
	localparam logic [1:0] PTR_XB = 2'h1;
	localparam logic [1:0] PTR_YA = 2'h2;
	localparam logic [1:0] PTR_YB = 2'h3;
endpackage : dsa_pkg

// file: dual_bus_data_space_access.sv
// Data space access logic: X read/write buses, Y read bus, lane select, alignment trap
`timescale 1ns/1ps
module dual_bus_data_space_access #(
	parameter logic [15:0] Y_BASE = dsa_pkg::Y_BASE,
	parameter logic [15:0] Y_END = dsa_pkg::Y_END,
	parameter logic [15:0] MEM_END = dsa_pkg::MEM_END
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// X read request from core
	input wire logic x_rd_req,
	input wire logic [15:0] x_rd_addr,
	input wire logic x_rd_byte,
	input wire logic x_rd_mac,
	input wire logic [1:0] x_rd_ptr_sel,
	// X write request from core
	input wire logic x_wr_req,
	input wire logic [15:0] x_wr_addr,
	input wire logic x_wr_byte,
	input wire logic [15:0] x_wr_data,
	input wire logic x_wr_acc_wb,
	// Y read request (MAC prefetch only)
	input wire logic y_rd_req,
	input wire logic [15:0] y_rd_addr,
	input wire logic [1:0] y_rd_ptr_sel,
	// Pointer post-modify request
	input wire logic pm_req,
	input wire logic [15:0] source_pointer,
	input wire logic pm_byte,
	input wire logic pm_dec,
	input wire logic pm_bitrev,
	input wire logic [15:0] pm_bitrev_mod,
	input wire logic pm_y_side,
	input wire logic pm_mod_en,
	input wire logic [15:0] pm_mod_start,
	input wire logic [15:0] pm_mod_end,
	// Memory X read port
	output logic mem_x_rd_en,
	output logic [14:0] mem_x_rd_word,
	input wire logic [15:0] mem_x_rd_data,
	// Memory Y read port
	output logic mem_y_rd_en,
	output logic [14:0] mem_y_rd_word,
	input wire logic [15:0] mem_y_rd_data,
	// Memory write port
	output logic [14:0] mem_wr_word,
	output logic [15:0] mem_wr_data,
	output logic mem_wr_lo,
	output logic mem_wr_hi,
	// Results to core
	output logic x_rd_valid,
	output logic [15:0] x_rd_data,
	output logic y_rd_valid,
	output logic [15:0] y_rd_data,
	output logic pm_valid,
	output logic [15:0] pm_next_pointer,
	output logic addr_error
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic mem_x_rd_en;
		logic [14:0] mem_x_rd_word;
		logic mem_y_rd_en;
		logic [14:0] mem_y_rd_word;
		logic [14:0] mem_wr_word;
		logic [15:0] mem_wr_data;
		logic mem_wr_lo;
		logic mem_wr_hi;
		logic x_pend;
		logic x_zero;
		logic x_byte;
		logic x_hi;
		logic y_pend;
		logic y_zero;
		logic x_rd_valid;
		logic [15:0] x_rd_data;
		logic y_rd_valid;
		logic [15:0] y_rd_data;
		logic pm_valid;
		logic [15:0] pm_next_pointer;
		logic addr_error;
	} state_s;

	state_s cur;
	state_s next_cur;

	// ----------------------------------------
	// Pointer update helpers
	// ----------------------------------------
	logic [15:0] lin_ptr;
	logic [15:0] rev_ptr;

	dsa_addr_step u_step (
		.ptr(source_pointer),
		.byte_op(pm_byte | pm_y_side ? pm_byte & ~pm_y_side : 1'b0),
		.dec(pm_dec),
		.mod_en(pm_mod_en),
		.mod_start(pm_mod_start),
		.mod_end(pm_mod_end),
		.next_ptr(lin_ptr)
	);

	dsa_bitrev u_rev (
		.ptr(source_pointer),
		.modifier(pm_bitrev_mod),
		.next_ptr(rev_ptr)
	);

	// ----------------------------------------
	// Address classification
	// ----------------------------------------
	function automatic logic in_y(input logic [15:0] a);
		in_y = (a >= Y_BASE) && (a <= Y_END);
	endfunction : in_y

	function automatic logic in_mem(input logic [15:0] a);
		in_mem = (a <= MEM_END);
	endfunction : in_mem

	logic x_misal;
	logic w_misal;
	logic y_misal;
	logic x_ptr_is_x;
	logic y_ptr_is_y;
	logic x_bad;
	logic y_bad;

	always_comb begin
		x_misal = x_rd_req && !x_rd_byte && x_rd_addr[0];
		w_misal = x_wr_req && !x_wr_byte && x_wr_addr[0];
		y_misal = y_rd_req && y_rd_addr[0];
		x_ptr_is_x = (x_rd_ptr_sel == dsa_pkg::PTR_XA) || (x_rd_ptr_sel == dsa_pkg::PTR_XB);
		y_ptr_is_y = (y_rd_ptr_sel == dsa_pkg::PTR_YA) || (y_rd_ptr_sel == dsa_pkg::PTR_YB);
		// Non-MAC reads see X and Y as one linear space
		x_bad = !in_mem(x_rd_addr) || (x_rd_mac && (!x_ptr_is_x || in_y(x_rd_addr)));
		y_bad = !in_mem(y_rd_addr) || !y_ptr_is_y || !in_y(y_rd_addr);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_cur = cur;
		// Stage 1: drive memory addresses
		next_cur.mem_x_rd_en = x_rd_req && !x_bad;
		next_cur.mem_x_rd_word = x_rd_addr[15:1];
		next_cur.x_pend = x_rd_req;
		next_cur.x_zero = x_bad;
		next_cur.x_byte = x_rd_byte;
		next_cur.x_hi = x_rd_addr[0];
		next_cur.mem_y_rd_en = y_rd_req && !y_bad;
		next_cur.mem_y_rd_word = y_rd_addr[15:1];
		next_cur.y_pend = y_rd_req;
		next_cur.y_zero = y_bad;
		// Single write path, any address up to MEM_END incl. accumulator write-back
		next_cur.mem_wr_word = x_wr_addr[15:1];
		next_cur.mem_wr_lo = x_wr_req && !w_misal && in_mem(x_wr_addr) &&
			(!x_wr_byte || !x_wr_addr[0]);
		next_cur.mem_wr_hi = x_wr_req && !w_misal && in_mem(x_wr_addr) &&
			(!x_wr_byte || x_wr_addr[0]);
		next_cur.mem_wr_data = x_wr_byte ? {x_wr_data[7:0], x_wr_data[7:0]} : x_wr_data;
		// Stage 2: return data
		next_cur.x_rd_valid = cur.x_pend;
		if (cur.x_zero) begin
			next_cur.x_rd_data = dsa_pkg::ZERO_WORD;
		end else if (cur.x_byte) begin
			next_cur.x_rd_data = {8'h00, cur.x_hi ? mem_x_rd_data[15:8] : mem_x_rd_data[7:0]};
		end else begin
			next_cur.x_rd_data = mem_x_rd_data;
		end
		next_cur.y_rd_valid = cur.y_pend;
		next_cur.y_rd_data = cur.y_zero ? dsa_pkg::ZERO_WORD : mem_y_rd_data;
		// Pointer post-modify
		next_cur.pm_valid = pm_req;
		if (pm_bitrev && !pm_y_side) begin
			next_cur.pm_next_pointer = rev_ptr;
		end else begin
			next_cur.pm_next_pointer = lin_ptr;
		end
		next_cur.addr_error = x_misal || w_misal || y_misal;
		if (srst) begin
			next_cur = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		cur <= next_cur;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mem_x_rd_en = cur.mem_x_rd_en;
	assign mem_x_rd_word = cur.mem_x_rd_word;
	assign mem_y_rd_en = cur.mem_y_rd_en;
	assign mem_y_rd_word = cur.mem_y_rd_word;
	assign mem_wr_word = cur.mem_wr_word;
	assign mem_wr_data = cur.mem_wr_data;
	assign mem_wr_lo = cur.mem_wr_lo;
	assign mem_wr_hi = cur.mem_wr_hi;
	assign x_rd_valid = cur.x_rd_valid;
	assign x_rd_data = cur.x_rd_data;
	assign y_rd_valid = cur.y_rd_valid;
	assign y_rd_data = cur.y_rd_data;
	assign pm_valid = cur.pm_valid;
	assign pm_next_pointer = cur.pm_next_pointer;
	assign addr_error = cur.addr_error;
endmodule : dual_bus_data_space_access

// file: testbench.sv
// Self-checking testbench for the data space access block
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 0, srst = 1, x_rd_req = 0, x_rd_byte = 0, x_rd_mac = 0, x_wr_req = 0, x_wr_byte = 0;
	logic x_wr_acc_wb = 0, y_rd_req = 0, pm_req = 0, pm_byte = 0, pm_dec = 0, pm_bitrev = 0, pm_y_side = 0;
	logic pm_mod_en = 0, mem_x_rd_en, mem_y_rd_en, mem_wr_lo, mem_wr_hi, x_rd_valid, y_rd_valid, pm_valid, addr_error;
	logic [1:0] x_rd_ptr_sel = 0, y_rd_ptr_sel = 0;
	logic [15:0] x_rd_addr = 0, x_wr_addr = 0, x_wr_data = 0, y_rd_addr = 0, source_pointer = 0, pm_bitrev_mod = 0;
	logic [15:0] pm_mod_start = 16'h0020, pm_mod_end = 16'h0027, mem_x_rd_data, mem_y_rd_data, x_rd_data, y_rd_data;
	logic [15:0] mem_wr_data, pm_next_pointer;
	logic [14:0] mem_x_rd_word, mem_y_rd_word, mem_wr_word;
	int n_fail = 0, cmp_count = 0;
	always #4 ref_clk = ~ref_clk;
	dual_bus_data_space_access i_dut (.*);
	dsa_mem_model i_mem (.*);
	// -----------------------------------------
	// Drivers and comparison
	// -----------------------------------------
	task chk(input string name, input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task rd(input logic y, byt, mac, input logic [1:0] sel, input logic [15:0] a, exp, input logic err);
		@(posedge ref_clk);
		{x_rd_req, y_rd_req} <= {!y, y};
		{x_rd_addr, y_rd_addr} <= {a, a};
		{x_rd_byte, x_rd_mac} <= {byt, mac};
		{x_rd_ptr_sel, y_rd_ptr_sel} <= {sel, sel};
		@(posedge ref_clk);
		{x_rd_req, y_rd_req} <= 2'b00;
		#1 chk("addr_error", 16'(addr_error), 16'(err));
		@(posedge ref_clk);
		#1 chk("read valid", 16'(y ? y_rd_valid : x_rd_valid), 16'h0001);
		chk("read data", y ? y_rd_data : x_rd_data, exp);
	endtask : rd
	task wr(input logic byt, acc, input logic [15:0] a, d, input logic err);
		@(posedge ref_clk);
		x_wr_req <= 1;
		{x_wr_byte, x_wr_acc_wb, x_wr_addr, x_wr_data} <= {byt, acc, a, d};
		@(posedge ref_clk);
		x_wr_req <= 0;
		#1 chk("addr_error", 16'(addr_error), 16'(err));
		chk("write lanes", 16'({mem_wr_hi, mem_wr_lo}), err ? 16'h0000 : (byt ? (a[0] ? 16'h0002 : 16'h0001) : 16'h0003));
	endtask : wr
	task pm(input logic [15:0] s, input logic [3:0] f, input logic [15:0] exp);
		@(posedge ref_clk);
		pm_req <= 1;
		source_pointer <= s;
		{pm_byte, pm_dec, pm_y_side, pm_mod_en} <= f;
		@(posedge ref_clk);
		pm_req <= 0;
		#1 chk("pointer valid", 16'(pm_valid), 16'h0001);
		chk("next pointer", pm_next_pointer, exp);
	endtask : pm
	// -----------------------------------------
	// Scenarios
	// -----------------------------------------
	task t_read();
		rd(0, 0, 0, 0, 16'h0004, 16'hFD02, 0);
		rd(0, 1, 0, 0, 16'h0003, 16'h00FE, 0);
		rd(0, 1, 0, 0, 16'h0002, 16'h0001, 0);
		rd(0, 0, 0, 0, 16'h0C02, 16'hFE01, 0);
		rd(0, 0, 0, 0, 16'h0005, 16'hFD02, 1);
	endtask : t_read
	task t_zero();
		rd(0, 0, 0, 0, 16'h2000, 16'h0000, 0);
		rd(0, 0, 1, dsa_pkg::PTR_XA, 16'h0C00, 16'h0000, 0);
		rd(0, 0, 1, dsa_pkg::PTR_XB, 16'h0010, 16'hF708, 0);
		rd(1, 0, 1, dsa_pkg::PTR_XA, 16'h0C04, 16'h0000, 0);
		rd(1, 0, 1, dsa_pkg::PTR_YA, 16'h0010, 16'h0000, 0);
		rd(1, 0, 1, dsa_pkg::PTR_YB, 16'h0C04, 16'hFD02, 0);
		rd(1, 0, 1, dsa_pkg::PTR_YA, 16'h0C05, 16'hFD02, 1);
	endtask : t_zero
	task t_write();
		wr(1, 0, 16'h0011, 16'h00AB, 0);
		rd(0, 0, 0, 0, 16'h0010, 16'hAB08, 0);
		wr(0, 0, 16'h0021, 16'h1234, 1);
		rd(0, 0, 0, 0, 16'h0020, 16'hEF10, 0);
		wr(0, 1, 16'h0C10, 16'h5A5A, 0);
		rd(1, 0, 1, dsa_pkg::PTR_YA, 16'h0C10, 16'h5A5A, 0);
	endtask : t_write
	task t_step();
		pm(16'h0010, 4'b1000, 16'h0011);
		pm(16'h0010, 4'b0000, 16'h0012);
		pm(16'h0010, 4'b0100, 16'h000E);
		pm(16'h0010, 4'b1010, 16'h0012);
		pm(16'h0026, 4'b0001, 16'h0020);
	endtask : t_step
	task test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 0;
		t_read();
		t_zero();
		t_write();
		t_step();
		test_done();
	end
	initial begin
		#20000;
		n_fail++;
		test_done();
	end
endmodule : testbench
